// ==== inc/pclk_pkg.sv ====
`default_nettype none
package pclk_pkg;

   // Programming port geometry
   localparam int REG_COUNT = 16;
   localparam int NIB_W     = 4;

   // Register targets of the nibble port
   localparam logic [3:0] IDX_POSTDIV = 4'h0;
   localparam logic [3:0] IDX_N_LO    = 4'h1;
   localparam logic [3:0] IDX_N_HI    = 4'h2;
   localparam logic [3:0] IDX_H_LO    = 4'h3;
   localparam logic [3:0] IDX_H_HI    = 4'h4;
   localparam logic [3:0] IDX_L_MOD   = 4'h5;
   localparam logic [3:0] IDX_DELAY   = 4'h6;
   localparam logic [3:0] IDX_S_MOD   = 4'h7;
   localparam logic [3:0] IDX_CTRL_A  = 4'h8;
   localparam logic [3:0] IDX_CTRL_B  = 4'h9;

   // Control nibble A and B bit positions
   localparam int CA_FB_SEL  = 0;
   localparam int CA_FB_OE   = 1;
   localparam int CA_SYS_SEL = 2;
   localparam int CA_TEST    = 3;
   localparam int CB_STOP    = 0;
   localparam int CB_ORST    = 1;

   // Largest post divider exponent, ratio 128
   localparam logic [3:0] POSTDIV_MAX = 4'h7;

   // Nibble image after reset: all zero, system clock from crystal
   localparam logic [63:0] REG_RESET = 64'h0000_0000_0000_0000;

   // Stored configurations of the ROM variant, nibble i at bits 4i+3:4i
   localparam logic [7:0][63:0] ROM_IMAGE = {
      64'h0000_0007_3F00_7F07, 64'h0000_0006_2F00_3F06,
      64'h0000_0007_1F01_1F05, 64'h0000_0003_0F02_0F04,
      64'h0000_0002_0F03_0703, 64'h0000_0002_0700_0302,
      64'h0000_0002_0300_0101, 64'h0000_0002_0100_0100};

   // APB map
   localparam int          APB_ADDR_W = 12;
   localparam logic [11:0] APB_CTRL   = 12'h000;
   localparam logic [11:0] APB_STATUS = 12'h004;
   localparam int          CTRL_ROM   = 0;
   localparam int          STS_ROM    = 0;
   localparam int          STS_SEL    = 1;
   localparam int          STS_RUN    = 4;
   localparam int          STS_TEST   = 5;
   localparam int          STS_SYSSEL = 6;
   localparam int          STS_UP     = 7;
   localparam int          STS_DN     = 8;

   // Phase detector state
   typedef enum logic [1:0] {PFD_IDLE, PFD_UP, PFD_DN} pclk_pfd_t;

endpackage
`default_nettype wire

// ==== inc/pclk_dly_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface pclk_dly_if;
   logic       tick;
   logic       load_clk;
   logic [3:0] delay;
   logic       delayed;
   modport core (output tick, output load_clk, output delay, input delayed);
   modport dly  (input tick, input load_clk, input delay, output delayed);
endinterface
`default_nettype wire

// ==== hw/pclk_dly.sv ====
`timescale 1ns/1ps
`default_nettype none
module pclk_dly (
   // Clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   // Link to the core
   pclk_dly_if.dly   lnk
);
   import pclk_pkg::*;

   typedef struct packed {
      logic [14:0] hist;
      logic        out;
   } pclk_dly_state_t;

   pclk_dly_state_t st;
   pclk_dly_state_t next_st;

   // History advances on system clock ticks only
   always_comb begin
      next_st = st;
      if (lnk.tick) begin
         next_st.hist = {st.hist[13:0], lnk.load_clk};
      end
      if (lnk.delay == 4'h0) begin
         next_st.out = lnk.load_clk;
      end else begin
         next_st.out = st.hist[4'(lnk.delay - 4'h1)];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign lnk.delayed = st.out;

   a_delay_zero_pass: assert property (@(posedge clk) disable iff (!nrst)
      lnk.delay == 4'h0 |=> lnk.delayed == $past(lnk.load_clk))
      else $error("zero delay does not follow the load clock");

   a_delay_one_tap: assert property (@(posedge clk) disable iff (!nrst)
      lnk.tick ##1 (lnk.delay == 4'h1) |=> lnk.delayed == $past(lnk.load_clk, 2))
      else $error("one tick delay tap is wrong");

endmodule // pclk_dly
`default_nettype wire

// ==== hw/pclk_top.sv ====
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pclk_top (
   // Clock and reset
   input  wire logic                            CORE_CLK,
   input  wire logic                            NRST,
   // APB slave
   input  wire logic                            PSEL,
   input  wire logic                            PENABLE,
   input  wire logic                            PWRITE,
   input  wire logic [pclk_pkg::APB_ADDR_W-1:0] PADDR,
   input  wire logic [31:0]                     PWDATA,
   output logic      [31:0]                     PRDATA,
   output logic                                 PREADY,
   output logic                                 PSLVERR,
   // Nibble programming port
   input  wire logic [3:0]                      REG_SELECT_LINES,
   input  wire logic [3:0]                      WRITE_NIBBLE_LINES,
   input  wire logic                            WRITE_ENABLE,
   // ROM variant control pins
   input  wire logic                            TEST_MODE_ENABLE,
   input  wire logic                            OSC_STOP,
   input  wire logic                            OSC_RESET_CTL,
   // Phase detector inputs
   input  wire logic                            PRIMARY_REFERENCE_INPUT,
   input  wire logic                            SECONDARY_REFERENCE_INPUT,
   input  wire logic                            SECONDARY_FEEDBACK_INPUT,
   // Primary feedback pin
   input  wire logic                            PRIMARY_FEEDBACK_I,
   output logic                                 PRIMARY_FEEDBACK_O,
   output logic                                 PRIMARY_FEEDBACK_OE,
   // Crystal
   input  wire logic                            CRYSTAL_IN,
   output logic                                 CRYSTAL_OUTPUT,
   // Clock outputs
   output logic                                 PIXEL_TICK,
   output logic                                 LOAD_CLOCK_OUT,
   output logic                                 DELAYED_LOAD_CLOCK,
   output logic                                 SYS_CLK,
   // Charge pump and filter
   output logic                                 PRIMARY_PUMP_UP,
   output logic                                 PRIMARY_PUMP_DN,
   output logic                                 SECONDARY_PUMP_UP,
   output logic                                 SECONDARY_PUMP_DN,
   output logic                                 PRIMARY_FILTER_NODE_PULLDOWN
);
   import pclk_pkg::*;

   typedef struct packed {
      logic [15:0][3:0] regs;
      logic             rom_variant;
      logic [2:0]       rom_sel;
      logic [6:0]       post_cnt;
      logic             pix_tick;
      logic [7:0]       n_cnt;
      logic [7:0]       h_cnt;
      logic             n_out;
      logic             h_out;
      logic [7:0]       l_cnt;
      logic             load_clk;
      logic [7:0]       s_cnt;
      logic             sys_div;
      logic             sys_tick;
      logic             sys_out;
      logic             fb_out;
      logic             crystal_q;
      logic             primary_reference_input_q;
      logic             secondary_reference_input_q;
      logic             primary_feedback_input_q;
      logic             secondary_feedback_input_q;
      pclk_pfd_t        pfd1;
      pclk_pfd_t        pfd2;
      logic             filt;
      logic [31:0]      prdata;
      logic             pslverr;
   } pclk_state_t;

   pclk_state_t st;
   pclk_state_t next_st;

   pclk_dly_if dly_link ();

   // Shared counter step: returns wrap flag and next count
   function automatic logic [8:0] cnt_step(input logic [7:0] cnt, input logic [7:0] modv);
      logic [8:0] res;
      res = {1'b0, cnt + 8'h01};
      if (cnt >= modv) begin
         res = {1'b1, 8'h00};
      end
      return res;
   endfunction

   // Post divider terminal count for ratio 2**code, clamped at 128
   function automatic logic [6:0] post_m1(input logic [3:0] code);
      logic [3:0] k;
      k = (code > POSTDIV_MAX) ? POSTDIV_MAX : code;
      return 7'((8'h01 << k) - 8'h01);
   endfunction

   // Rising-edge phase frequency detector step
   function automatic pclk_pfd_t pfd_next(input pclk_pfd_t cur, input logic r, input logic f);
      pclk_pfd_t res;
      res = cur;
      if (r && f) begin
         res = PFD_IDLE;
      end else if (r) begin
         res = (cur == PFD_DN) ? PFD_IDLE : PFD_UP;
      end else if (f) begin
         res = (cur == PFD_UP) ? PFD_IDLE : PFD_DN;
      end
      return res;
   endfunction

   // Effective configuration and controls
   logic [15:0][3:0] cfg;
   logic             fb_sel;
   logic             fb_oe;
   logic             sys_sel;
   logic             test_on;
   logic             osc_halt;
   logic             osc_rst;
   logic             osc_tick;
   logic             primary_reference_input_rise;
   logic             secondary_reference_input_rise;
   logic             primary_feedback_input_rise;
   logic             secondary_feedback_input_rise;
   logic [31:0]      status_word;
   logic [8:0]       n_step;
   logic [8:0]       h_step;
   logic [8:0]       l_step;
   logic [8:0]       s_step;

   // ROM variant takes its image from the stored table, bus variant from writes
   always_comb begin
      cfg      = st.rom_variant ? ROM_IMAGE[st.rom_sel] : st.regs;
      fb_sel   = cfg[IDX_CTRL_A][CA_FB_SEL];
      fb_oe    = cfg[IDX_CTRL_A][CA_FB_OE];
      sys_sel  = cfg[IDX_CTRL_A][CA_SYS_SEL];
      test_on  = st.rom_variant ? TEST_MODE_ENABLE : cfg[IDX_CTRL_A][CA_TEST];
      osc_halt = st.rom_variant ? OSC_STOP : cfg[IDX_CTRL_B][CB_STOP];
      osc_rst  = st.rom_variant ? OSC_RESET_CTL : cfg[IDX_CTRL_B][CB_ORST];
   end

   // Edge detectors; inputs are synchronous so one stage suffices
   assign primary_reference_input_rise = PRIMARY_REFERENCE_INPUT && !st.primary_reference_input_q;
   assign secondary_reference_input_rise = SECONDARY_REFERENCE_INPUT && !st.secondary_reference_input_q;
   assign primary_feedback_input_rise = PRIMARY_FEEDBACK_I && !st.primary_feedback_input_q;
   assign secondary_feedback_input_rise = SECONDARY_FEEDBACK_INPUT && !st.secondary_feedback_input_q;

   // Oscillator modelled as one tick per core cycle, or per step in test mode
   assign osc_tick = !osc_halt && !osc_rst && (test_on ? secondary_reference_input_rise : 1'b1);

   // Counter steps
   assign n_step = cnt_step(st.n_cnt, {cfg[IDX_N_HI], cfg[IDX_N_LO]});
   assign h_step = cnt_step(st.h_cnt, {cfg[IDX_H_HI], cfg[IDX_H_LO]});
   assign l_step = cnt_step(st.l_cnt, {4'h0, cfg[IDX_L_MOD]});
   assign s_step = cnt_step(st.s_cnt, {4'h0, cfg[IDX_S_MOD]});

   // Status word for APB reads
   always_comb begin
      status_word               = 32'h0000_0000;
      status_word[STS_ROM]      = st.rom_variant;
      status_word[STS_SEL +: 3] = st.rom_sel;
      status_word[STS_RUN]      = !osc_halt && !osc_rst;
      status_word[STS_TEST]     = test_on;
      status_word[STS_SYSSEL]   = sys_sel;
      status_word[STS_UP]       = (st.pfd1 == PFD_UP);
      status_word[STS_DN]       = (st.pfd1 == PFD_DN);
   end

   // Next state of the whole block
   always_comb begin
      next_st          = st;
      next_st.pix_tick = 1'b0;
      next_st.sys_tick = 1'b0;

      // APB: read data and error latched in setup, valid through access
      if (PSEL && !PENABLE) begin
         next_st.pslverr = !((PADDR == APB_CTRL) || (PADDR == APB_STATUS));
         if (PADDR == APB_STATUS) begin
            next_st.prdata = status_word;
         end else if (PADDR == APB_CTRL) begin
            next_st.prdata = {31'h0000_0000, st.rom_variant};
         end else begin
            next_st.prdata = 32'h0000_0000;
         end
      end
      if (PSEL && PENABLE && PWRITE && (PADDR == APB_CTRL)) begin
         next_st.rom_variant = PWDATA[CTRL_ROM];
      end

      // Level-sensitive nibble port; every enabled cycle rewrites the target
      if (WRITE_ENABLE) begin
         if (st.rom_variant) begin
            next_st.rom_sel = REG_SELECT_LINES[2:0];
         end else begin
            next_st.regs[REG_SELECT_LINES] = WRITE_NIBBLE_LINES;
         end
      end

      // Post divider feeding the pixel clock
      if (osc_tick) begin
         if (st.post_cnt >= post_m1(cfg[IDX_POSTDIV])) begin
            next_st.post_cnt = 7'h00;
            next_st.pix_tick = 1'b1;
         end else begin
            next_st.post_cnt = 7'(st.post_cnt + 7'h01);
         end
      end

      // Feedback counters; test strobe reloads N regardless of ticks
      if (test_on && secondary_feedback_input_rise) begin
         next_st.n_cnt = 8'h00;
      end else if (osc_tick) begin
         next_st.n_cnt = n_step[7:0];
         if (n_step[8]) begin
            next_st.n_out = !st.n_out;
         end
      end
      if (osc_tick) begin
         next_st.h_cnt = h_step[7:0];
         if (h_step[8]) begin
            next_st.h_out = !st.h_out;
         end
      end

      // Load clock toggles each L wrap of pixel ticks
      if (st.pix_tick) begin
         next_st.l_cnt = l_step[7:0];
         if (l_step[8]) begin
            next_st.load_clk = !st.load_clk;
         end
      end

      // S counter gives the internal system clock and its tick
      if (osc_tick) begin
         next_st.s_cnt = s_step[7:0];
         if (s_step[8]) begin
            next_st.sys_div  = !st.sys_div;
            next_st.sys_tick = 1'b1;
         end
      end

      // Output muxes registered to keep pins glitch free
      next_st.fb_out    = fb_sel ? st.h_out : st.n_out;
      next_st.sys_out   = sys_sel ? st.sys_div : st.crystal_q;
      next_st.crystal_q = !CRYSTAL_IN;

      // Phase detectors; reset clears the primary, test mode the secondary
      next_st.pfd1 = osc_rst ? PFD_IDLE : pfd_next(st.pfd1, primary_reference_input_rise, primary_feedback_input_rise);
      next_st.pfd2 = test_on ? PFD_IDLE : pfd_next(st.pfd2, secondary_reference_input_rise, secondary_feedback_input_rise);
      next_st.filt = osc_rst;

      // Edge history
      next_st.primary_reference_input_q = PRIMARY_REFERENCE_INPUT;
      next_st.secondary_reference_input_q = SECONDARY_REFERENCE_INPUT;
      next_st.primary_feedback_input_q = PRIMARY_FEEDBACK_I;
      next_st.secondary_feedback_input_q = SECONDARY_FEEDBACK_INPUT;
   end

   // State register; reset leaves select bits low
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         st      <= '0;
         st.regs <= REG_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Delay line for the delayed load clock
   assign dly_link.tick     = st.sys_tick;
   assign dly_link.load_clk = st.load_clk;
   assign dly_link.delay    = cfg[IDX_DELAY];

   pclk_dly u_dly (
      .clk  (CORE_CLK),
      .nrst (NRST),
      .lnk  (dly_link)
   );

   // Output drive
   assign PRDATA                       = st.prdata;
   assign PREADY                       = 1'b1;
   assign PSLVERR                      = st.pslverr;
   assign PRIMARY_FEEDBACK_O           = st.fb_out;
   assign PRIMARY_FEEDBACK_OE          = fb_oe;
   assign CRYSTAL_OUTPUT               = st.crystal_q;
   assign PIXEL_TICK                   = st.pix_tick;
   assign LOAD_CLOCK_OUT               = st.load_clk;
   assign DELAYED_LOAD_CLOCK           = dly_link.delayed;
   assign SYS_CLK                      = st.sys_out;
   assign PRIMARY_PUMP_UP              = (st.pfd1 == PFD_UP);
   assign PRIMARY_PUMP_DN              = (st.pfd1 == PFD_DN);
   assign SECONDARY_PUMP_UP            = (st.pfd2 == PFD_UP);
   assign SECONDARY_PUMP_DN            = (st.pfd2 == PFD_DN);
   assign PRIMARY_FILTER_NODE_PULLDOWN = st.filt;

   a_write_hits_target: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      WRITE_ENABLE && !st.rom_variant
      |=> st.regs[$past(REG_SELECT_LINES)] == $past(WRITE_NIBBLE_LINES))
      else $error("nibble write did not land in the selected register");

   a_write_spares_other: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      WRITE_ENABLE && !st.rom_variant
      |=> st.regs[4'($past(REG_SELECT_LINES) + 4'h1)]
          == $past(st.regs[4'(REG_SELECT_LINES + 4'h1)]))
      else $error("write disturbed a neighbouring register");

   a_rom_select_latch: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      WRITE_ENABLE && st.rom_variant ##1 !WRITE_ENABLE [*2]
      |-> st.rom_sel == $past(REG_SELECT_LINES[2:0], 2))
      else $error("configuration select not held after enable");

   a_stop_halts_pixel: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      osc_halt [*2] |=> !PIXEL_TICK)
      else $error("pixel tick while oscillator stopped");

   a_feedback_route: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      $stable(fb_sel) && fb_sel |=> PRIMARY_FEEDBACK_O == $past(st.h_out))
      else $error("primary feedback not sourced from H counter");

   a_sysclk_crystal: assert property (@(posedge CORE_CLK)
      !NRST ##1 NRST [*2] |-> SYS_CLK == $past(st.crystal_q))
      else $error("system clock not from crystal after reset");

   a_test_loads_n: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      test_on && secondary_feedback_input_rise |=> st.n_cnt == 8'h00)
      else $error("test strobe did not load the N counter");

   a_test_single_step: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      test_on && !secondary_reference_input_rise |=> !PIXEL_TICK)
      else $error("pixel tick in test mode without a step");

   a_reset_pulls_filter: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      osc_rst |=> PRIMARY_FILTER_NODE_PULLDOWN && !PIXEL_TICK && !PRIMARY_PUMP_UP)
      else $error("oscillator reset did not halt and pull the filter");

   a_pfd_rising_up: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      !osc_rst && st.pfd1 == PFD_IDLE && primary_reference_input_rise && !primary_feedback_input_rise |=> PRIMARY_PUMP_UP)
      else $error("reference rising edge did not raise pump up");

endmodule // pclk_top
`default_nettype wire

// ==== test/pclk_nib_writer.sv ====
`timescale 1ns/1ps
`default_nettype none
// Processor side of the nibble programming port
module pclk_nib_writer (
   // Clock
   input  wire logic  clk,
   // Nibble port
   output logic [3:0] sel,
   output logic [3:0] dat,
   output logic       we
);
   // Lines start quiet; released lines later show the inverse unless keep is set, never a tidy copy
   initial begin
      sel = 4'h0;
      dat = 4'h0;
      we  = 1'b0;
   end
   // Select and data stand still for the whole enable time
   task automatic wr(input logic [3:0] idx, input logic [3:0] val, input bit keep);
      @(posedge clk);
      sel <= idx;
      dat <= val;
      we  <= 1'b1;
      repeat (2) @(posedge clk);
      we  <= 1'b0;
      @(posedge clk);
      if (!keep) begin
         sel <= ~idx;
         dat <= ~val;
      end
   endtask
   // Oscillator reset pulse after reprogramming; also clears the stop bit
   task automatic osc_pulse();
      wr(4'h9, 4'h2, 1'b0);
      wr(4'h9, 4'h0, 1'b0);
   endtask
endmodule // pclk_nib_writer
`default_nettype wire

// ==== test/tb_pclk_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_pclk_top;
   import pclk_pkg::*;
   logic        clk, nrst, psel, pen, pwr, tm, ostop, orst, primary_reference_input, secondary_reference_input, secondary_feedback_input, fbd, xin;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, perr, fbo, fboe, xout, pix, ldc, dlc, sys, pu1, pd1, pu2, pd2, pdn;
   logic [3:0]  sel, dat;
   logic        we, err;
   wire         fb_wire = fboe ? fbo : fbd;
   int          err_total, samples_checked, c, d;

   pclk_nib_writer w (.clk(clk), .sel(sel), .dat(dat), .we(we));
   pclk_top dut (.CORE_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(perr),
      .REG_SELECT_LINES(sel), .WRITE_NIBBLE_LINES(dat), .WRITE_ENABLE(we),
      .TEST_MODE_ENABLE(tm), .OSC_STOP(ostop), .OSC_RESET_CTL(orst),
      .PRIMARY_REFERENCE_INPUT(primary_reference_input), .SECONDARY_REFERENCE_INPUT(secondary_reference_input),
      .SECONDARY_FEEDBACK_INPUT(secondary_feedback_input), .PRIMARY_FEEDBACK_I(fb_wire),
      .PRIMARY_FEEDBACK_O(fbo), .PRIMARY_FEEDBACK_OE(fboe), .CRYSTAL_IN(xin),
      .CRYSTAL_OUTPUT(xout), .PIXEL_TICK(pix), .LOAD_CLOCK_OUT(ldc),
      .DELAYED_LOAD_CLOCK(dlc), .SYS_CLK(sys), .PRIMARY_PUMP_UP(pu1),
      .PRIMARY_PUMP_DN(pd1), .SECONDARY_PUMP_UP(pu2), .SECONDARY_PUMP_DN(pd2),
      .PRIMARY_FILTER_NODE_PULLDOWN(pdn));

   // Free-running core clock, 8 ns period
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Verdict in one place
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t %s seen %h expected %h", $time, m, seen, exp);
      end
   endtask
   // One APB transfer; the wait for pready is bounded
   task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] wd);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      pen <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         err_total++;
         stop_test();
      end
      rd = prdata;
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // Pixel ticks, or toggles of a clock output, over n cycles
   task automatic count(input int k, input int n, output int cnt);
      logic p, v;
      cnt = 0;
      p = (k == 1) ? fbo : (k == 2) ? sys : 1'b0;
      repeat (n) begin
         @(posedge clk);
         v = (k == 1) ? fbo : (k == 2) ? sys : pix;
         if (k == 0 ? v === 1'b1 : v !== p) cnt++;
         p = v;
      end
   endtask
   task automatic t_reset_bus();
      chk({fboe, pdn, pready}, 3'h1, "reset levels");
      apb(1'b0, APB_STATUS, 32'h0);
      chk({rd[STS_SYSSEL], rd[STS_ROM], err}, 3'h0, "status after reset");
      apb(1'b0, 12'h010, 32'h0);
      chk(err, 1'b1, "unmapped read error");
      chk(rd, 32'h0, "unmapped read data");
      xin <= 1'b1;
      repeat (4) @(posedge clk);
      chk({sys, xout}, 2'h0, "sys from crystal high");
      xin <= 1'b0;
      repeat (4) @(posedge clk);
      chk({sys, xout}, 2'h3, "sys from crystal low");
      $display("test reset_bus done");
   endtask
   task automatic t_postdiv();
      logic [3:0] e [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hF};
      foreach (e[i]) begin
         w.wr(IDX_POSTDIV, e[i], 1'b0);
         repeat (260) @(posedge clk);
         count(0, 256, c);
         chk(c, 256 >> (e[i] > 7 ? 7 : e[i]), "pixel tick count");
      end
      w.wr(IDX_POSTDIV, 4'h0, 1'b0);
      $display("test postdiv done");
   endtask
   task automatic t_sysclk_route();
      w.wr(IDX_S_MOD, 4'h1, 1'b0);
      w.wr(IDX_CTRL_A, 4'h4, 1'b0);
      repeat (4) @(posedge clk);
      count(2, 16, c);
      chk(c, 8, "sys from S divider");
      for (int i = 10; i < 16; i++) w.wr(i[3:0], 4'hF, 1'b0);
      apb(1'b0, APB_STATUS, 32'h0);
      chk({rd[STS_TEST], rd[STS_SYSSEL], rd[STS_RUN]}, 3'h3, "targeted writes");
      w.wr(IDX_N_LO, 4'h0, 1'b0);
      w.wr(IDX_H_LO, 4'h3, 1'b0);
      w.wr(IDX_CTRL_A, 4'h2, 1'b0);
      repeat (4) @(posedge clk);
      count(1, 16, c);
      chk({fboe, c[7:0]}, {1'b1, 8'd16}, "N on feedback");
      w.wr(IDX_CTRL_A, 4'h3, 1'b0);
      repeat (8) @(posedge clk);
      count(1, 16, c);
      chk({fboe, c[7:0]}, {1'b1, 8'd4}, "H on feedback");
      w.wr(IDX_CTRL_A, 4'h0, 1'b0);
      repeat (2) @(posedge clk);
      chk(fboe, 1'b0, "feedback released");
      $display("test sysclk_route done");
   endtask
   task automatic t_delay();
      logic [3:0] dv [3] = '{4'h0, 4'h1, 4'h7};
      w.wr(IDX_L_MOD, 4'hF, 1'b0);
      w.wr(IDX_S_MOD, 4'h0, 1'b0); // One system tick per core cycle
      w.osc_pulse();
      foreach (dv[i]) begin
         w.wr(IDX_DELAY, dv[i], 1'b0);
         repeat (40) @(posedge clk);
         for (c = 0; c < 40 && ldc === dlc; c++) @(posedge clk);
         for (d = 0; d < 40 && ldc !== dlc; d++) @(posedge clk);
         chk(d, dv[i] + 1, "load clock delay");
      end
      $display("test delay done");
   endtask
   task automatic t_osc_ctl();
      w.wr(IDX_CTRL_B, 4'h1, 1'b0);
      repeat (4) @(posedge clk);
      count(0, 32, c);
      chk(c, 0, "stopped oscillator");
      w.wr(IDX_CTRL_B, 4'h2, 1'b0);
      repeat (4) @(posedge clk);
      count(0, 16, c);
      chk({pdn, c[7:0]}, {1'b1, 8'd0}, "oscillator held in reset");
      w.wr(IDX_CTRL_B, 4'h0, 1'b0);
      repeat (4) @(posedge clk);
      count(0, 16, c);
      chk({pdn, c[7:0]}, {1'b0, 8'd16}, "oscillator resumed");
      $display("test osc_ctl done");
   endtask
   // Phase detectors see rising edges only; falls leave the pumps idle
   task automatic t_pfd();
      primary_reference_input <= 1'b1;
      repeat (3) @(posedge clk);
      chk({pu1, pd1}, 2'h2, "ref rise gives up");
      fbd <= 1'b1;
      repeat (3) @(posedge clk);
      chk({pu1, pd1}, 2'h0, "fbk rise clears");
      primary_reference_input <= 1'b0;
      fbd <= 1'b0;
      repeat (3) @(posedge clk);
      chk({pu1, pd1}, 2'h0, "falls ignored");
      secondary_feedback_input <= 1'b1;
      repeat (3) @(posedge clk);
      chk({pu2, pd2}, 2'h1, "secondary fbk rise");
      secondary_feedback_input <= 1'b0;
      $display("test pfd done");
   endtask
   task automatic t_testmode();
      w.wr(IDX_CTRL_A, 4'h8, 1'b0);
      repeat (4) @(posedge clk);
      c = 0;
      repeat (3) begin
         @(posedge clk);
         secondary_reference_input <= 1'b1;
         count(0, 4, d);
         c += d;
         secondary_reference_input <= 1'b0;
         count(0, 3, d);
         c += d;
      end
      chk(c, 3, "single steps");
      secondary_feedback_input <= 1'b1;
      repeat (2) @(posedge clk);
      secondary_feedback_input <= 1'b0;
      repeat (2) @(posedge clk);
      chk({pu2, pd2, pix}, 3'h0, "no step from feedback strobe");
      w.wr(IDX_CTRL_A, 4'h0, 1'b0);
      $display("test testmode done");
   endtask
   task automatic t_rom();
      apb(1'b1, APB_CTRL, 32'h1);
      for (int k = 0; k < 8; k++) begin
         w.wr(k[3:0], 4'h5, 1'b1);
         orst <= 1'b1;
         repeat (2) @(posedge clk);
         chk(pdn, 1'b1, "reset pin pulls filter");
         orst <= 1'b0;
         apb(1'b0, APB_STATUS, 32'h0);
         chk({rd[3:1], rd[STS_ROM]}, {k[2:0], 1'b1}, "rom select latched");
      end
      ostop <= 1'b1;
      tm <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b0, APB_STATUS, 32'h0);
      chk(rd[STS_RUN], 1'b0, "stop pin");
      chk(rd[STS_TEST], 1'b1, "test mode pin");
      $display("test rom done");
   endtask
   initial begin
      {nrst, psel, pen, pwr, tm, ostop, orst, primary_reference_input, secondary_reference_input, secondary_feedback_input, fbd, xin} = '0;
      paddr = '0;
      pwdata = '0;
      err_total = 0;
      samples_checked = 0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_reset_bus();
      t_postdiv();
      t_sysclk_route();
      t_delay();
      t_osc_ctl();
      t_pfd();
      t_testmode();
      t_rom();
      stop_test();
   end
endmodule // tb_pclk_top
`default_nettype wire
